/* File: rtl/als_status_refresh.sv */
// ambient light command registers, crossing flags and refresh scheduling
`timescale 1ns/10ps
`default_nettype none
module als_status_refresh #(
  parameter int ms_cycles = als_pkg::ms_cycles_default
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata,
  input wire logic [15:0] adc_result,
  input wire logic adc_done,
  output logic meas_start,
  output logic [15:0] resolution_e4,
  output logic low_bound_cross_flag,
  output logic high_bound_cross_flag
);
  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  logic [15:0] config_r;
  logic [15:0] high_bound_r;
  logic [15:0] low_bound_r;
  logic [2:0] power_save_r;
  logic [15:0] result_r;
  logic low_flag_r;
  logic high_flag_r;
  logic [15:0] rdata_r;
  logic start_r;
  logic [15:0] res_r;
  logic [12:0] period_nxt;
  logic [12:0] it_ms;
  logic [12:0] wait_ms;
  logic [15:0] res_nxt;
  logic [15:0] rdata_nxt;
  logic wr_config;
  logic wr_high;
  logic wr_low;
  logic wr_power_save;

  wire logic int_en = config_r[als_pkg::cfg_int_en_bit];
  wire logic [3:0] integration_time_sel = config_r[als_pkg::cfg_it_lo +: 4];
  wire logic [1:0] light_gain_sel = config_r[als_pkg::cfg_gain_lo +: 2];
  wire logic power_save_on = power_save_r[als_pkg::ps_on_bit];
  wire logic [1:0] power_save_level = power_save_r[als_pkg::ps_level_lo +: 2];
  wire logic rd_flags = cmd_rd && (cmd_code == als_pkg::cmd_flags);
  wire logic low_cross = adc_done && int_en && (adc_result < low_bound_r);
  wire logic high_cross = adc_done && int_en && (adc_result > high_bound_r);

  refresh_if rlink ();

  refresh_timer #(.ms_cycles(ms_cycles)) u_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .link(rlink)
  );

  // status and result have no write decode, so writes to them fall away
  always_comb begin
    wr_config = 1'b0;
    wr_high = 1'b0;
    wr_low = 1'b0;
    wr_power_save = 1'b0;
    if (cmd_wr) begin
      unique case (cmd_code)
        als_pkg::cmd_config: wr_config = 1'b1;
        als_pkg::cmd_high_bound: wr_high = 1'b1;
        als_pkg::cmd_low_bound: wr_low = 1'b1;
        als_pkg::cmd_power_save: wr_power_save = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      config_r <= als_pkg::config_reset;
    end else if (wr_config) begin
      config_r <= cmd_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_bound_r <= als_pkg::high_bound_reset;
    end else if (wr_high) begin
      high_bound_r <= cmd_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_bound_r <= als_pkg::low_bound_reset;
    end else if (wr_low) begin
      low_bound_r <= cmd_wdata;
    end
  end

  // reserved bits 15:3 are dropped on write and read back as zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_save_r <= als_pkg::power_save_reset;
    end else if (wr_power_save) begin
      power_save_r <= cmd_wdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // refresh period
  // ----------------------------------------------------------------
  // codes outside 0000..0011 fall back to the shortest integration time
  always_comb begin
    unique case (integration_time_sel)
      als_pkg::it_code_c1: begin
        it_ms = als_pkg::it_ms_c1;
        res_nxt = als_pkg::res_c1;
      end
      als_pkg::it_code_c2: begin
        it_ms = als_pkg::it_ms_c2;
        res_nxt = als_pkg::res_c2;
      end
      als_pkg::it_code_c3: begin
        it_ms = als_pkg::it_ms_c3;
        res_nxt = als_pkg::res_c3;
      end
      default: begin
        it_ms = als_pkg::it_ms_c0;
        res_nxt = als_pkg::res_c0;
      end
    endcase
  end

  always_comb begin
    unique case (power_save_level)
      2'h0: wait_ms = als_pkg::wait_ms_l1;
      2'h1: wait_ms = als_pkg::wait_ms_l2;
      2'h2: wait_ms = als_pkg::wait_ms_l3;
      2'h3: wait_ms = als_pkg::wait_ms_l4;
    endcase
  end

  // without power saving the sensor converts back to back
  always_comb begin
    if (power_save_on) begin
      period_nxt = wait_ms + it_ms;
    end else begin
      period_nxt = it_ms;
    end
  end

  assign rlink.period_ms = period_nxt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_r <= 1'b0;
      res_r <= als_pkg::res_c0;
    end else begin
      start_r <= rlink.tick;
      res_r <= res_nxt;
    end
  end

  // ----------------------------------------------------------------
  // result and crossing flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_r <= 16'h0000;
    end else if (adc_done) begin
      result_r <= adc_result;
    end
  end

  // flags clear on a status read, but a crossing in that same cycle wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_flag_r <= 1'b0;
    end else if (low_cross) begin
      low_flag_r <= 1'b1;
    end else if (rd_flags) begin
      low_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      high_flag_r <= 1'b0;
    end else if (high_cross) begin
      high_flag_r <= 1'b1;
    end else if (rd_flags) begin
      high_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cmd_code)
      als_pkg::cmd_config: rdata_nxt = config_r;
      als_pkg::cmd_high_bound: rdata_nxt = high_bound_r;
      als_pkg::cmd_low_bound: rdata_nxt = low_bound_r;
      als_pkg::cmd_power_save: rdata_nxt = {13'h0000, power_save_r};
      als_pkg::cmd_result: rdata_nxt = result_r;
      als_pkg::cmd_flags: rdata_nxt = {low_flag_r, high_flag_r, 14'h0000};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_r <= 16'h0000;
    end else if (cmd_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign cmd_rdata = rdata_r;
  assign meas_start = start_r;
  assign resolution_e4 = res_r;
  assign low_bound_cross_flag = low_flag_r;
  assign high_bound_cross_flag = high_flag_r;

  // gain only scales the front end; period and flags do not depend on it
  logic unused_gain;
  assign unused_gain = ^light_gain_sel;
endmodule : als_status_refresh
`default_nettype wire

/* File: rtl/als_pkg.sv */
// constants shared by the light sensor status and refresh logic
`default_nettype none
package als_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] cmd_config = 8'h00;
  localparam logic [7:0] cmd_high_bound = 8'h01;
  localparam logic [7:0] cmd_low_bound = 8'h02;
  localparam logic [7:0] cmd_power_save = 8'h03;
  localparam logic [7:0] cmd_result = 8'h04;
  localparam logic [7:0] cmd_flags = 8'h06;
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int flag_low_bit = 15;
  localparam int flag_high_bit = 14;
  localparam int ps_on_bit = 0;
  localparam int ps_level_lo = 1;
  localparam int cfg_int_en_bit = 1;
  localparam int cfg_it_lo = 6;
  localparam int cfg_gain_lo = 11;
  localparam logic [15:0] config_reset = 16'h0000;
  localparam logic [15:0] high_bound_reset = 16'h0000;
  localparam logic [15:0] low_bound_reset = 16'h0000;
  localparam logic [2:0] power_save_reset = 3'h0;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int clk_mhz = 100;
  localparam int ns_per_ms = 1000000;
  localparam int clk_period_ns = 1000 / clk_mhz;
  localparam int ms_cycles_default = ns_per_ms / clk_period_ns;
  // idle wait per power save level; with power saving on, period = wait + integration time
  localparam logic [12:0] wait_ms_l1 = 13'd500;
  localparam logic [12:0] wait_ms_l2 = 13'd1000;
  localparam logic [12:0] wait_ms_l3 = 13'd2000;
  localparam logic [12:0] wait_ms_l4 = 13'd4000;
  localparam logic [12:0] it_ms_c0 = 13'd100;
  localparam logic [12:0] it_ms_c1 = 13'd200;
  localparam logic [12:0] it_ms_c2 = 13'd400;
  localparam logic [12:0] it_ms_c3 = 13'd800;
  localparam logic [3:0] it_code_c0 = 4'h0;
  localparam logic [3:0] it_code_c1 = 4'h1;
  localparam logic [3:0] it_code_c2 = 4'h2;
  localparam logic [3:0] it_code_c3 = 4'h3;
  // resolution in units of 0.0001 lx per count
  localparam logic [15:0] res_c0 = 16'd288;
  localparam logic [15:0] res_c1 = 16'd144;
  localparam logic [15:0] res_c2 = 16'd72;
  localparam logic [15:0] res_c3 = 16'd36;
endpackage : als_pkg
`default_nettype wire

/* File: rtl/refresh_if.sv */
// link between the register logic and the refresh timer
`timescale 1ns/10ps
`default_nettype none
interface refresh_if;
  logic [12:0] period_ms;
  logic tick;
  modport ctrl (output period_ms, input tick);
  modport timer (input period_ms, output tick);
endinterface : refresh_if
`default_nettype wire

/* File: rtl/refresh_timer.sv */
// millisecond divider and measurement repeat counter
`timescale 1ns/10ps
`default_nettype none
module refresh_timer #(
  parameter int ms_cycles = als_pkg::ms_cycles_default
) (
  input wire logic sys_clk,
  input wire logic rst,
  refresh_if.timer link
);
  logic [16:0] div_r;
  logic ms_en_r;
  logic [12:0] ms_cnt_r;
  logic tick_r;

  // one cycle enable per millisecond
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= 17'h00000;
      ms_en_r <= 1'b0;
    end else if (div_r == 17'(ms_cycles - 1)) begin
      div_r <= 17'h00000;
      ms_en_r <= 1'b1;
    end else begin
      div_r <= div_r + 17'h00001;
      ms_en_r <= 1'b0;
    end
  end

  // a shortened period takes effect at once instead of waiting out the old one
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ms_cnt_r <= 13'h0000;
      tick_r <= 1'b0;
    end else if (ms_en_r && (ms_cnt_r + 13'h0001 >= link.period_ms)) begin
      ms_cnt_r <= 13'h0000;
      tick_r <= 1'b1;
    end else begin
      if (ms_en_r) begin
        ms_cnt_r <= ms_cnt_r + 13'h0001;
      end
      tick_r <= 1'b0;
    end
  end

  assign link.tick = tick_r;
endmodule : refresh_timer
`default_nettype wire

/* File: sim/host_model.sv */
// host side of the command port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic [7:0] cmd_code,
  output logic cmd_wr,
  output logic [15:0] cmd_wdata,
  output logic cmd_rd
);
  initial begin
    {cmd_code, cmd_wr, cmd_wdata, cmd_rd} = '0;
  end
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge sys_clk);
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(negedge sys_clk);
    cmd_wr = 1'b0;
    // stale data must not look valid
    cmd_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] c);
    @(negedge sys_clk);
    cmd_code = c;
    cmd_rd = 1'b1;
    @(negedge sys_clk);
    cmd_rd = 1'b0;
  endtask : rd
endmodule : host_model
`default_nettype wire

/* File: sim/als_status_refresh_props.sv */
// concurrent checks on the status and refresh ports
`timescale 1ns/10ps
`default_nettype none
module als_status_refresh_props #(
  parameter int ms_cycles = 10
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_wr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_rd,
  input wire logic [15:0] cmd_rdata,
  input wire logic [15:0] adc_result,
  input wire logic adc_done,
  input wire logic meas_start,
  input wire logic [15:0] resolution_e4,
  input wire logic low_bound_cross_flag,
  input wire logic high_bound_cross_flag
);
  logic [15:0] low_r, high_r;
  logic int_en_r;
  logic rd_flags;
  logic low_hit;
  logic high_hit;
  assign rd_flags = cmd_rd && cmd_code == als_pkg::cmd_flags;
  assign low_hit = adc_done && int_en_r && adc_result < low_r;
  assign high_hit = adc_done && int_en_r && adc_result > high_r;
  // shadow bounds so crossings can be predicted from the ports
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      low_r <= 16'h0000;
      high_r <= 16'h0000;
      int_en_r <= 1'b0;
    end else if (cmd_wr) begin
      if (cmd_code == als_pkg::cmd_low_bound) low_r <= cmd_wdata;
      if (cmd_code == als_pkg::cmd_high_bound) high_r <= cmd_wdata;
      if (cmd_code == als_pkg::cmd_config) int_en_r <= cmd_wdata[als_pkg::cfg_int_en_bit];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_low_set;
    adc_done && int_en_r && adc_result < low_r |=> low_bound_cross_flag;
  endproperty
  a_low_set: assert property (p_low_set) else $error("low flag missed");
  property p_high_set;
    adc_done && int_en_r && adc_result > high_r |=> high_bound_cross_flag;
  endproperty
  a_high_set: assert property (p_high_set) else $error("high flag missed");
  property p_word;
    rd_flags |=> cmd_rdata == {$past(low_bound_cross_flag), $past(high_bound_cross_flag), 14'h0000};
  endproperty
  a_word: assert property (p_word) else $error("status word wrong");
  property p_clear;
    rd_flags && !adc_done |=> !low_bound_cross_flag && !high_bound_cross_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_hold;
    low_bound_cross_flag && !rd_flags |=> low_bound_cross_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("low flag dropped");
  property p_cause;
    ($rose(low_bound_cross_flag) |-> $past(low_hit)) and
      ($rose(high_bound_cross_flag) |-> $past(high_hit));
  endproperty
  a_cause: assert property (p_cause) else $error("flag without crossing");
  property p_res;
    resolution_e4 inside {16'h0120, 16'h0090, 16'h0048, 16'h0024};
  endproperty
  a_res: assert property (p_res) else $error("bad resolution");
  property p_ps_read;
    cmd_rd && cmd_code == als_pkg::cmd_power_save |=> cmd_rdata[15:3] == 13'h0000;
  endproperty
  a_ps_read: assert property (p_ps_read) else $error("reserved bits set");
  property p_pulse;
    meas_start |=> !meas_start [*8];
  endproperty
  a_pulse: assert property (p_pulse) else $error("start pulse too long");
endmodule : als_status_refresh_props
bind als_status_refresh als_status_refresh_props #(.ms_cycles(ms_cycles)) u_props (
  .sys_clk(sys_clk), .rst(rst), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
  .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata), .adc_result(adc_result), .adc_done(adc_done),
  .meas_start(meas_start), .resolution_e4(resolution_e4),
  .low_bound_cross_flag(low_bound_cross_flag), .high_bound_cross_flag(high_bound_cross_flag));
`default_nettype wire

/* File: sim/als_int_status_refresh_test.sv */
// self-checking bench for status flags and refresh timing
`timescale 1ns/10ps
`default_nettype none
module als_int_status_refresh_test;
  localparam int ms_c = 2;
  logic sys_clk, rst, adc_done, cmd_wr, cmd_rd, meas_start, lo_f, hi_f;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, cmd_rdata, adc_result, res;
  int errors, total_checks, n;
  typedef struct {logic [15:0] ps; logic [15:0] cfg; int ms; logic [15:0] r;} row_type;
  row_type rows[6] = '{'{16'h0001, 16'h0800, 600, 16'h0120}, '{16'h0003, 16'h0840, 1200, 16'h0090},
    '{16'h0005, 16'h0880, 2400, 16'h0048}, '{16'h0007, 16'h08c0, 4800, 16'h0024},
    '{16'h0000, 16'h0900, 100, 16'h0120}, '{16'h0006, 16'h08c0, 800, 16'h0024}};
  host_model h (.sys_clk(sys_clk), .cmd_code(cmd_code), .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata),
    .cmd_rd(cmd_rd));
  als_status_refresh #(.ms_cycles(ms_c)) dut (.sys_clk(sys_clk), .rst(rst), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
    .adc_result(adc_result), .adc_done(adc_done), .meas_start(meas_start),
    .resolution_e4(res), .low_bound_cross_flag(lo_f), .high_bound_cross_flag(hi_f));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic conv(input logic [15:0] v);
    @(negedge sys_clk);
    adc_result = v;
    adc_done = 1'b1;
    @(negedge sys_clk);
    adc_done = 1'b0;
    adc_result = ~v;
  endtask : conv
  // the first gap after a change may mix old and new periods
  task automatic period();
    n = 0;
    while (meas_start !== 1'b1 && n < 20000) begin @(negedge sys_clk); n++; end
    n = 0;
    do begin @(negedge sys_clk); n++; end while (meas_start !== 1'b1 && n < 20000);
  endtask : period
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    // the refresh rows need about 40,000 cycles at most
    #700000;
    errors++;
    report_and_stop();
  end
  initial begin
    {rst, adc_done, adc_result, errors, total_checks} = '0;
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check(cmd_rdata, 16'h0000);
    check({res[13:0], lo_f, hi_f}, {14'h0120, 2'b00});
    foreach (rows[i]) begin
      h.wr(als_pkg::cmd_power_save, rows[i].ps);
      h.wr(als_pkg::cmd_config, rows[i].cfg);
      period();
      check(16'(n), 16'(rows[i].ms * ms_c));
      check(res, rows[i].r);
    end
    h.rd(als_pkg::cmd_power_save);
    check(cmd_rdata, 16'h0006);
    h.wr(als_pkg::cmd_power_save, 16'hffff);
    h.rd(als_pkg::cmd_power_save);
    check(cmd_rdata, 16'h0007);
    h.wr(als_pkg::cmd_low_bound, 16'h0064);
    h.wr(als_pkg::cmd_high_bound, 16'h00c8);
    conv(16'h0000);
    h.rd(als_pkg::cmd_flags);
    check(cmd_rdata, 16'h0000);
    h.wr(als_pkg::cmd_config, 16'h0802);
    conv(16'h0063);
    h.rd(als_pkg::cmd_flags);
    check(cmd_rdata, 16'h8000);
    h.rd(als_pkg::cmd_flags);
    check(cmd_rdata, 16'h0000);
    conv(16'h00c9);
    h.wr(als_pkg::cmd_flags, 16'h0000);
    h.rd(als_pkg::cmd_flags);
    check(cmd_rdata, 16'h4000);
    conv(16'h0064);
    conv(16'h00c8);
    h.wr(als_pkg::cmd_flags, 16'hffff);
    h.rd(als_pkg::cmd_flags);
    check(cmd_rdata, 16'h0000);
    // a crossing in the very cycle of the status read must survive the read
    fork
      h.rd(als_pkg::cmd_flags);
      conv(16'h0000);
    join
    check(cmd_rdata, 16'h0000);
    check({15'h0000, lo_f}, 16'h0001);
    h.rd(als_pkg::cmd_flags);
    check(cmd_rdata, 16'h8000);
    h.wr(als_pkg::cmd_config, 16'h08c2);
    conv(16'hffff);
    check({15'h0000, hi_f}, 16'h0001);
    check(res, 16'h0024);
    h.rd(als_pkg::cmd_result);
    check(cmd_rdata, 16'hffff);
    h.rd(als_pkg::cmd_config);
    check(cmd_rdata, 16'h08c2);
    h.rd(als_pkg::cmd_low_bound);
    check(cmd_rdata, 16'h0064);
    h.rd(als_pkg::cmd_high_bound);
    check(cmd_rdata, 16'h00c8);
    // mid-run reset must clear read data, flags and registers
    rst = 1'b1;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check({14'h0000, lo_f, hi_f}, 16'h0000);
    check(cmd_rdata, 16'h0000);
    check(res, 16'h0120);
    h.rd(als_pkg::cmd_config);
    check(cmd_rdata, 16'h0000);
    h.rd(als_pkg::cmd_power_save);
    check(cmd_rdata, 16'h0000);
    report_and_stop();
  end
endmodule : als_int_status_refresh_test
`default_nettype wire
